// *** design/gpib_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_device
  import gpib_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  gpib_if.dev bus,
  input wire logic nv_load_i,
  input wire logic [5:0] nv_addr_i,
  input wire logic addr_wr_i,
  input wire logic [5:0] addr_i,
  input wire logic master_i,
  input wire trig_src_t trig_src_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_eoi_i,
  output logic tx_ready_o,
  input wire logic srq_req_i,
  input wire logic [5:0] status_i,
  input wire logic rtl_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_eoi_o,
  input wire logic rx_ready_i,
  output logic [5:0] addr_o,
  output logic nv_save_o,
  output logic talk_o,
  output logic listen_o,
  output logic remote_o,
  output logic lockout_o,
  output logic trigger_o,
  output logic dev_clear_o
);
  ah_state_t ah_ff;
  sh_state_t sh_ff;
  logic [5:0] addr_ff;
  logic nv_save_ff;
  logic listen_ff, talk_ff, spms_ff, remote_ff, lockout_ff, srq_ff;
  logic [7:0] byte_ff;
  logic eoi_in_ff, cmd_ff;
  logic nrfd_ff, ndac_ff;
  logic [7:0] dio_ff;
  logic dio_oe_ff, dav_ff, eoi_out_ff;
  logic [SETTLE_W-1:0] settle_ff;
  logic tx_ready_ff, trig_ff, dcl_ff;
  logic fifo_in_ready;

  // bus address: loop master stores 31..60 and answers at that minus 30
  wire logic [4:0] pa = master_i ? 5'(addr_ff - ADDR_MS_OFS) : addr_ff[4:0];

  // acceptor is live for every command and for data only while listening
  wire logic ah_act = bus.atn | listen_ff;
  wire logic can_take = bus.atn | fifo_in_ready;
  wire logic take = (ah_ff == AH_HOLD);
  wire logic [6:0] b7 = byte_ff[6:0];
  wire logic c = take & cmd_ff;
  wire logic d = take & ~cmd_ff;

  // command decode; secondaries and parallel poll bytes fall through unused
  wire logic mla = c & is_addr(b7, GRP_LISTEN, pa);
  wire logic mta = c & is_addr(b7, GRP_TALK, pa);
  wire logic ota = c & (b7[6:5] == GRP_TALK) & ~is_addr(b7, GRP_TALK, pa);
  wire logic unl = c & (b7 == CMD_UNL);
  wire logic gtl = c & (b7 == CMD_GTL) & listen_ff;
  wire logic sdc = c & (b7 == CMD_SDC) & listen_ff;
  wire logic get = c & (b7 == CMD_GET) & listen_ff;
  wire logic llo = c & (b7 == CMD_LLO);
  wire logic dcl = c & (b7 == CMD_DCL);
  wire logic spe = c & (b7 == CMD_SPE);
  wire logic spd = c & (b7 == CMD_SPD);
  wire logic exec = d & (byte_ff == EXEC_CHAR) & remote_ff;

  wire logic trig_ev = (get & (trig_src_i == TRIG_GET))
                     | (mta & ~talk_ff & (trig_src_i == TRIG_TALK))
                     | (exec & (trig_src_i == TRIG_EXEC));

  // talker source side
  wire logic sh_act = talk_ff & ~bus.atn;
  wire logic sh_idle = (sh_ff == SH_IDLE);
  wire logic tx_take = sh_idle & sh_act & ~spms_ff & tx_valid_i & ~tx_ready_ff;
  wire logic sp_take = sh_idle & sh_act & spms_ff;
  wire logic [7:0] stb = {1'b0, srq_ff, status_i};
  wire logic sent = (sh_ff == SH_DAV) & ~bus.ndac;

  wire logic wr_ok = addr_wr_i & addr_in_range(addr_i, master_i);
  wire logic nv_ok = nv_load_i & addr_in_range(nv_addr_i, master_i);

  // open-collector pulls only; no ATN or IFC driver exists at all
  assign bus.d_dio_o = dio_ff;
  assign bus.d_dio_oe = dio_oe_ff;
  assign bus.d_dav_o = 1'b1;
  assign bus.d_dav_oe = dav_ff;
  assign bus.d_nrfd_o = 1'b1;
  assign bus.d_nrfd_oe = nrfd_ff;
  assign bus.d_ndac_o = 1'b1;
  assign bus.d_ndac_oe = ndac_ff;
  assign bus.d_eoi_o = 1'b1;
  assign bus.d_eoi_oe = eoi_out_ff;
  assign bus.d_srq_o = 1'b1;
  assign bus.d_srq_oe = srq_ff;

  assign addr_o = addr_ff;
  assign nv_save_o = nv_save_ff;
  assign talk_o = talk_ff;
  assign listen_o = listen_ff;
  assign remote_o = remote_ff;
  assign lockout_o = lockout_ff;
  assign trigger_o = trig_ff;
  assign dev_clear_o = dcl_ff;
  assign tx_ready_o = tx_ready_ff;

  // address store; the outside keeps it across power cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= ADDR_DEF;
      nv_save_ff <= 1'b0;
    end else if (ce_i) begin
      nv_save_ff <= wr_ok;
      if (wr_ok) begin
        addr_ff <= addr_i;
      end else if (nv_ok) begin
        addr_ff <= nv_addr_i;
      end
    end
  end

  // acceptor handshake; NRFD stays held while the receive fifo is full and ATN is not asserted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ah_ff <= AH_IDLE;
      nrfd_ff <= 1'b0;
      ndac_ff <= 1'b0;
      byte_ff <= 8'h00;
      eoi_in_ff <= 1'b0;
      cmd_ff <= 1'b0;
    end else if (ce_i) begin
      case (ah_ff)
        AH_IDLE: begin
          if (ah_act) begin
            ndac_ff <= 1'b1;
            nrfd_ff <= ~can_take;
            ah_ff <= AH_RDY;
          end
        end
        AH_RDY: begin
          if (!ah_act) begin
            ndac_ff <= 1'b0;
            nrfd_ff <= 1'b0;
            ah_ff <= AH_IDLE;
          end else if (bus.dav && !nrfd_ff) begin
            byte_ff <= bus.dio;
            eoi_in_ff <= bus.eoi;
            cmd_ff <= bus.atn;
            nrfd_ff <= 1'b1;
            ah_ff <= AH_HOLD;
          end else begin
            nrfd_ff <= ~can_take;
          end
        end
        AH_HOLD: begin
          ndac_ff <= 1'b0;
          ah_ff <= AH_ACC;
        end
        AH_ACC: begin
          if (!bus.dav) begin
            if (ah_act) begin
              ndac_ff <= 1'b1;
              nrfd_ff <= ~can_take;
              ah_ff <= AH_RDY;
            end else begin
              nrfd_ff <= 1'b0;
              ah_ff <= AH_IDLE;
            end
          end
        end
        default: ah_ff <= AH_IDLE;
      endcase
    end
  end

  // addressing, serial poll mode, remote/local, clear and trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      listen_ff <= 1'b0;
      talk_ff <= 1'b0;
      spms_ff <= 1'b0;
      remote_ff <= 1'b0;
      lockout_ff <= 1'b0;
      trig_ff <= 1'b0;
      dcl_ff <= 1'b0;
    end else if (ce_i) begin
      trig_ff <= trig_ev;
      dcl_ff <= dcl | sdc;
      if (bus.ifc) begin
        listen_ff <= 1'b0;
        talk_ff <= 1'b0;
        spms_ff <= 1'b0;
      end else begin
        if (mla) begin
          listen_ff <= 1'b1;
        end else if (unl || mta) begin
          listen_ff <= 1'b0;
        end
        if (mta) begin
          talk_ff <= 1'b1;
        end else if (mla || ota) begin
          talk_ff <= 1'b0;
        end
        if (spe) begin
          spms_ff <= 1'b1;
        end else if (spd) begin
          spms_ff <= 1'b0;
        end
      end
      if (!bus.ren) begin
        remote_ff <= 1'b0;
        lockout_ff <= 1'b0;
      end else begin
        if (mla) begin
          remote_ff <= 1'b1;
        end else if (gtl || (rtl_i && !lockout_ff)) begin
          remote_ff <= 1'b0;
        end
        if (llo) begin
          lockout_ff <= 1'b1;
        end
      end
    end
  end

  // service request stays until the status byte is taken; a new request wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_ff <= 1'b0;
    end else if (ce_i) begin
      srq_ff <= srq_req_i | (srq_ff & ~(sent & spms_ff));
    end
  end

  // source handshake; any ATN or loss of talk address aborts the byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_ff <= SH_IDLE;
      dio_ff <= 8'h00;
      dio_oe_ff <= 1'b0;
      dav_ff <= 1'b0;
      eoi_out_ff <= 1'b0;
      settle_ff <= '0;
      tx_ready_ff <= 1'b0;
    end else if (ce_i) begin
      tx_ready_ff <= tx_take;
      case (sh_ff)
        SH_IDLE: begin
          if (tx_take || sp_take) begin
            dio_ff <= spms_ff ? stb : tx_data_i;
            eoi_out_ff <= ~spms_ff & tx_eoi_i;
            dio_oe_ff <= 1'b1;
            settle_ff <= SETTLE_LOAD;
            sh_ff <= SH_SETTLE;
          end
        end
        SH_SETTLE: begin
          if (!sh_act) begin
            dio_oe_ff <= 1'b0;
            eoi_out_ff <= 1'b0;
            sh_ff <= SH_IDLE;
          end else if (settle_ff != '0) begin
            settle_ff <= settle_ff - SETTLE_W'(1);
          end else if (!bus.nrfd) begin
            dav_ff <= 1'b1;
            sh_ff <= SH_DAV;
          end
        end
        SH_DAV: begin
          if (!sh_act || sent) begin
            dav_ff <= 1'b0;
            dio_oe_ff <= 1'b0;
            eoi_out_ff <= 1'b0;
            sh_ff <= SH_IDLE;
          end
        end
        default: sh_ff <= SH_IDLE;
      endcase
    end
  end

  // data bytes land here only while listening; device clear flushes it
  gpib_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(dcl_ff),
    .in_valid_i(d & listen_ff),
    .in_ready_o(fifo_in_ready),
    .in_data_i({eoi_in_ff, byte_ff}),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o({rx_eoi_o, rx_data_o})
  );
endmodule : gpib_device
`default_nettype wire

// *** shared/gpib_pkg.sv ***
// How it works
// - talker sends bytes with DAV/NRFD/NDAC handshake
// - acceptor drives NRFD and NDAC fully
// - basic talker, serial poll, MLA unaddresses talk
// - data goes out only while addressed talk
// - secondary addresses are ignored entirely
// - basic listener, MTA unaddresses, data when listening
// - service request line asserted until serially polled
// - remote/local follows REN, MLA, GTL, LLO
// - parallel poll commands are ignored
// - DCL or addressed SDC clears device functions
// - GET while listening triggers next setup
// - never drives ATN or IFC
// - every driven line is open collector
// - primary address limited to 0..30
// - address defaults to 18 when never set
// - new address saved to non-volatile store
// - addressed commands need listen address first
// - loop master address range is 31..60
// - trigger source picks execute, talk or GET
package gpib_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int T1_NS = 2000;
  localparam int T1_CYC = (T1_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int IFC_US = 100;
  localparam int IFC_CYC = IFC_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_W = 6;
  localparam int IFC_W = 12;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(T1_CYC - 1);
  localparam logic [IFC_W-1:0] IFC_LOAD = IFC_W'(IFC_CYC - 1);
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 9;
  localparam logic [5:0] ADDR_DEF = 6'h12;
  localparam logic [5:0] ADDR_SA_MAX = 6'h1e;
  localparam logic [5:0] ADDR_MS_MIN = 6'h1f;
  localparam logic [5:0] ADDR_MS_MAX = 6'h3c;
  localparam logic [5:0] ADDR_MS_OFS = 6'h1e;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [7:0] EXEC_CHAR = 8'h58;

  typedef enum logic [1:0] {TRIG_EXEC, TRIG_TALK, TRIG_GET, TRIG_OFF} trig_src_t;
  typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV} sh_state_t;
  typedef enum logic [1:0] {AH_IDLE, AH_RDY, AH_HOLD, AH_ACC} ah_state_t;

  function automatic logic is_addr(input logic [6:0] b, input logic [1:0] grp,
                                   input logic [4:0] pa);
    return (b[6:5] == grp) && (b[4:0] == pa);
  endfunction : is_addr

  function automatic logic addr_in_range(input logic [5:0] a, input logic master);
    return master ? (a >= ADDR_MS_MIN && a <= ADDR_MS_MAX) : (a <= ADDR_SA_MAX);
  endfunction : addr_in_range
endpackage : gpib_pkg

// *** shared/gpib_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// every line is open collector: a party pulls it true when oe and o are high
interface gpib_if;
  logic [7:0] d_dio_o;
  logic d_dio_oe;
  logic d_dav_o, d_dav_oe, d_nrfd_o, d_nrfd_oe, d_ndac_o, d_ndac_oe;
  logic d_eoi_o, d_eoi_oe, d_srq_o, d_srq_oe;
  logic [7:0] c_dio_o;
  logic c_dio_oe;
  logic c_dav_o, c_dav_oe, c_nrfd_o, c_nrfd_oe, c_ndac_o, c_ndac_oe;
  logic c_eoi_o, c_eoi_oe, c_atn_o, c_atn_oe, c_ifc_o, c_ifc_oe, c_ren_o, c_ren_oe;
  // resolved levels, high means asserted (line pulled low)
  logic [7:0] dio;
  logic dav, nrfd, ndac, eoi, srq, atn, ifc, ren;

  assign dio = (d_dio_oe ? d_dio_o : 8'h00) | (c_dio_oe ? c_dio_o : 8'h00);
  assign dav = (d_dav_oe & d_dav_o) | (c_dav_oe & c_dav_o);
  assign nrfd = (d_nrfd_oe & d_nrfd_o) | (c_nrfd_oe & c_nrfd_o);
  assign ndac = (d_ndac_oe & d_ndac_o) | (c_ndac_oe & c_ndac_o);
  assign eoi = (d_eoi_oe & d_eoi_o) | (c_eoi_oe & c_eoi_o);
  assign srq = d_srq_oe & d_srq_o;
  assign atn = c_atn_oe & c_atn_o;
  assign ifc = c_ifc_oe & c_ifc_o;
  assign ren = c_ren_oe & c_ren_o;

  modport dev (
    input dio, dav, nrfd, ndac, eoi, atn, ifc, ren,
    output d_dio_o, d_dio_oe, d_dav_o, d_dav_oe, d_nrfd_o, d_nrfd_oe,
    output d_ndac_o, d_ndac_oe, d_eoi_o, d_eoi_oe, d_srq_o, d_srq_oe
  );
  modport ctl (
    input dio, dav, nrfd, ndac, eoi, srq,
    output c_dio_o, c_dio_oe, c_dav_o, c_dav_oe, c_nrfd_o, c_nrfd_oe,
    output c_ndac_o, c_ndac_oe, c_eoi_o, c_eoi_oe, c_atn_o, c_atn_oe,
    output c_ifc_o, c_ifc_oe, c_ren_o, c_ren_oe
  );
endinterface : gpib_if
`default_nettype wire

// *** design/gpib_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff;
  logic [AW:0] cnt_ff;
  logic full_ff, valid_ff;

  wire logic push = in_valid_i & ~full_ff;
  wire logic pop = valid_ff & out_ready_i;
  wire logic [AW:0] nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready_o = ~full_ff;
  assign out_valid_o = valid_ff;
  assign out_data_o = mem[rd_ff];

  always_ff @(posedge clk_i) begin
    if (push && ce_i) begin
      mem[wr_ff] <= in_data_i;
    end
  end

  // flags are registered so both sides see flop outputs
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clr_i)) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wr_ff <= (wr_ff == PTR_LAST) ? '0 : wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == PTR_LAST) ? '0 : rd_ff + AW'(1);
      end
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == CNT_FULL);
      valid_ff <= (nxt_cnt != '0);
    end
  end
endmodule : gpib_fifo
`default_nettype wire

// *** design/gpib_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_controller
  import gpib_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  gpib_if.ctl bus,
  input wire logic atn_i,
  input wire logic ren_i,
  input wire logic ifc_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_eoi_i,
  output logic tx_ready_o,
  input wire logic rx_en_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_eoi_o,
  output logic srq_o,
  output logic ifc_busy_o
);
  sh_state_t sh_ff;
  ah_state_t ah_ff;
  logic atn_ff, ren_ff, ifc_ff, srq_ff;
  logic [IFC_W-1:0] ifc_cnt_ff;
  logic [7:0] dio_ff;
  logic dio_oe_ff, dav_ff, eoi_ff, nrfd_ff, ndac_ff;
  logic [SETTLE_W-1:0] settle_ff;
  logic tx_ready_ff, rx_valid_ff;
  logic [7:0] rx_data_ff;
  logic rx_eoi_ff;

  wire logic tx_take = (sh_ff == SH_IDLE) & tx_valid_i & ~ifc_ff & ~tx_ready_ff;
  // the controller listens only to data, never to its own commands
  wire logic ah_act = rx_en_i & ~atn_ff & ~ifc_ff;

  assign bus.c_dio_o = dio_ff;
  assign bus.c_dio_oe = dio_oe_ff;
  assign bus.c_dav_o = 1'b1;
  assign bus.c_dav_oe = dav_ff;
  assign bus.c_nrfd_o = 1'b1;
  assign bus.c_nrfd_oe = nrfd_ff;
  assign bus.c_ndac_o = 1'b1;
  assign bus.c_ndac_oe = ndac_ff;
  assign bus.c_eoi_o = 1'b1;
  assign bus.c_eoi_oe = eoi_ff;
  assign bus.c_atn_o = 1'b1;
  assign bus.c_atn_oe = atn_ff;
  assign bus.c_ifc_o = 1'b1;
  assign bus.c_ifc_oe = ifc_ff;
  assign bus.c_ren_o = 1'b1;
  assign bus.c_ren_oe = ren_ff;
  assign tx_ready_o = tx_ready_ff;
  assign rx_valid_o = rx_valid_ff;
  assign rx_data_o = rx_data_ff;
  assign rx_eoi_o = rx_eoi_ff;
  assign srq_o = srq_ff;
  assign ifc_busy_o = ifc_ff;

  // management lines; IFC is held for its full minimum time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      atn_ff <= 1'b0;
      ren_ff <= 1'b0;
      ifc_ff <= 1'b0;
      ifc_cnt_ff <= '0;
      srq_ff <= 1'b0;
    end else if (ce_i) begin
      atn_ff <= atn_i;
      ren_ff <= ren_i;
      srq_ff <= bus.srq;
      if (ifc_i && !ifc_ff) begin
        ifc_ff <= 1'b1;
        ifc_cnt_ff <= IFC_LOAD;
      end else if (ifc_cnt_ff != '0) begin
        ifc_cnt_ff <= ifc_cnt_ff - IFC_W'(1);
      end else begin
        ifc_ff <= 1'b0;
      end
    end
  end

  // source handshake for commands and data alike
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_ff <= SH_IDLE;
      dio_ff <= 8'h00;
      dio_oe_ff <= 1'b0;
      dav_ff <= 1'b0;
      eoi_ff <= 1'b0;
      settle_ff <= '0;
      tx_ready_ff <= 1'b0;
    end else if (ce_i) begin
      tx_ready_ff <= tx_take;
      case (sh_ff)
        SH_IDLE: begin
          if (tx_take) begin
            dio_ff <= tx_data_i;
            eoi_ff <= tx_eoi_i;
            dio_oe_ff <= 1'b1;
            settle_ff <= SETTLE_LOAD;
            sh_ff <= SH_SETTLE;
          end
        end
        SH_SETTLE: begin
          if (settle_ff != '0) begin
            settle_ff <= settle_ff - SETTLE_W'(1);
          end else if (!bus.nrfd) begin
            dav_ff <= 1'b1;
            sh_ff <= SH_DAV;
          end
        end
        SH_DAV: begin
          if (!bus.ndac) begin
            dav_ff <= 1'b0;
            dio_oe_ff <= 1'b0;
            eoi_ff <= 1'b0;
            sh_ff <= SH_IDLE;
          end
        end
        default: sh_ff <= SH_IDLE;
      endcase
    end
  end

  // acceptor handshake for bytes the device talks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ah_ff <= AH_IDLE;
      nrfd_ff <= 1'b0;
      ndac_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_eoi_ff <= 1'b0;
    end else if (ce_i) begin
      rx_valid_ff <= 1'b0;
      case (ah_ff)
        AH_IDLE: begin
          if (ah_act) begin
            ndac_ff <= 1'b1;
            nrfd_ff <= 1'b0;
            ah_ff <= AH_RDY;
          end
        end
        AH_RDY: begin
          if (!ah_act) begin
            ndac_ff <= 1'b0;
            ah_ff <= AH_IDLE;
          end else if (bus.dav) begin
            rx_data_ff <= bus.dio;
            rx_eoi_ff <= bus.eoi;
            rx_valid_ff <= 1'b1;
            nrfd_ff <= 1'b1;
            ah_ff <= AH_HOLD;
          end
        end
        AH_HOLD: begin
          ndac_ff <= 1'b0;
          ah_ff <= AH_ACC;
        end
        AH_ACC: begin
          if (!bus.dav) begin
            nrfd_ff <= 1'b0;
            ndac_ff <= ah_act;
            ah_ff <= ah_act ? AH_RDY : AH_IDLE;
          end
        end
        default: ah_ff <= AH_IDLE;
      endcase
    end
  end
endmodule : gpib_controller
`default_nettype wire

// *** verif/gpib_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] dio,
  input wire logic dav,
  input wire logic nrfd,
  input wire logic ndac,
  input wire logic atn,
  input wire logic d_dav_o,
  input wire logic d_dav_oe,
  input wire logic d_nrfd_o,
  input wire logic d_ndac_o,
  input wire logic d_srq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence src_go;
    $rose(dav);
  endsequence
  sequence acc_take;
    ##[0:4] nrfd ##[0:8] !ndac;
  endsequence
  dav_waits_a: assert property (src_go |-> !$past(nrfd))
    else $error("dav rose while nrfd held");
  acc_takes_a: assert property (src_go |-> acc_take)
    else $error("acceptor did not take byte");
  dav_holds_a: assert property (dav && ndac && !atn |=> dav)
    else $error("dav dropped before acceptance");
  dav_drops_a: assert property (dav && !ndac |-> ##[1:2] !dav)
    else $error("dav not released after acceptance");
  dio_steady_a: assert property (dav && $past(dav) |-> $stable(dio))
    else $error("data changed under dav");
  ndac_back_a: assert property ($fell(dav) && !atn |-> ##[0:3] ndac)
    else $error("ndac not reasserted");
  // device decides on the previous cycle, so look one back
  talk_no_atn_a: assert property ($rose(d_dav_oe && d_dav_o) |-> !$past(atn))
    else $error("device sourced under atn");
  oc_pulls_a: assert property (d_dav_o && d_nrfd_o && d_ndac_o && d_srq_o)
    else $error("driver not open collector");
endmodule : gpib_chk
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gpib_pkg::*;
;
  logic clk_i = 0, rst_i = 1, atn_i = 0, ren_i = 1, ifc_i = 0, c_tv = 0, c_te = 0, rx_en = 0;
  logic wr = 0, master = 0, d_tv = 0, d_te = 0, srq_rq = 0, rx_rdy = 0;
  logic [7:0] c_td = 8'h00, d_td = 8'h00;
  logic [5:0] waddr = 6'h00, stat = 6'h00;
  trig_src_t tsrc = TRIG_GET;
  logic d_rdy, c_rdy, c_rv, c_re, c_srq, ifc_bsy, rv, re, save, talk, lsn, rem, lock, trig, clr;
  logic [7:0] c_rd, rd;
  logic [5:0] addr;
  int err_count = 0, comparisons = 0, n_trig = 0, n_clr = 0, n_save = 0;
  localparam logic [7:0] MLA = {1'b0, GRP_LISTEN, ADDR_DEF[4:0]};
  localparam logic [7:0] MTA = {1'b0, GRP_TALK, ADDR_DEF[4:0]};
  gpib_if gpib_if_inst ();
  gpib_device gpib_device_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .bus(gpib_if_inst.dev), .nv_load_i(1'b0), .nv_addr_i(waddr), .addr_wr_i(wr),
    .addr_i(waddr), .master_i(master), .trig_src_i(tsrc), .tx_valid_i(d_tv), .tx_data_i(d_td),
    .tx_eoi_i(d_te), .tx_ready_o(d_rdy), .srq_req_i(srq_rq), .status_i(stat), .rtl_i(1'b0),
    .rx_valid_o(rv), .rx_data_o(rd), .rx_eoi_o(re), .rx_ready_i(rx_rdy), .addr_o(addr),
    .nv_save_o(save), .talk_o(talk), .listen_o(lsn), .remote_o(rem), .lockout_o(lock),
    .trigger_o(trig), .dev_clear_o(clr));
  gpib_controller gpib_controller_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .bus(gpib_if_inst.ctl), .atn_i(atn_i), .ren_i(ren_i), .ifc_i(ifc_i), .tx_valid_i(c_tv),
    .tx_data_i(c_td), .tx_eoi_i(c_te), .tx_ready_o(c_rdy), .rx_en_i(rx_en), .rx_valid_o(c_rv),
    .rx_data_o(c_rd), .rx_eoi_o(c_re), .srq_o(c_srq), .ifc_busy_o(ifc_bsy));
  gpib_chk gpib_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .dio(gpib_if_inst.dio),
    .dav(gpib_if_inst.dav), .nrfd(gpib_if_inst.nrfd), .ndac(gpib_if_inst.ndac),
    .atn(gpib_if_inst.atn), .d_dav_o(gpib_if_inst.d_dav_o), .d_dav_oe(gpib_if_inst.d_dav_oe),
    .d_nrfd_o(gpib_if_inst.d_nrfd_o), .d_ndac_o(gpib_if_inst.d_ndac_o),
    .d_srq_o(gpib_if_inst.d_srq_o));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // one-cycle pulses are counted so a test can judge them later
  always @(posedge clk_i) begin
    if (trig === 1'b1) n_trig <= n_trig + 1;
    if (clr === 1'b1) n_clr <= n_clr + 1;
    if (save === 1'b1) n_save <= n_save + 1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // a wait that ran out of cycles is a failure, not a silent pass
  task automatic lim(input logic ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR %0t wait limit reached", $time);
    end
  endtask : lim
  task automatic ctl_start(input logic a, input logic [7:0] b);
    atn_i <= a;
    step(3);
    c_tv <= 1'b1;
    c_td <= b;
    for (int i = 0; i < 400 && c_rdy !== 1'b1; i++) step(1);
    lim(c_rdy === 1'b1);
    c_tv <= 1'b0;
  endtask : ctl_start
  task automatic ctl_send(input logic a, input logic [7:0] b);
    ctl_start(a, b);
    for (int i = 0; i < 400 && gpib_if_inst.dav !== 1'b1; i++) step(1);
    lim(gpib_if_inst.dav === 1'b1);
    for (int i = 0; i < 400 && gpib_if_inst.dav !== 1'b0; i++) step(1);
    lim(gpib_if_inst.dav === 1'b0);
    step(4);
  endtask : ctl_send
  task automatic ctl_rx(input logic [7:0] exp);
    for (int i = 0; i < 400 && c_rv !== 1'b1; i++) step(1);
    lim(c_rv === 1'b1);
    chk(c_rd, exp);
  endtask : ctl_rx
  task automatic pop(input logic [7:0] exp);
    for (int i = 0; i < 400 && rv !== 1'b1; i++) step(1);
    lim(rv === 1'b1);
    chk(rd, exp);
    rx_rdy <= 1'b1;
    step(1);
    rx_rdy <= 1'b0;
    step(1);
  endtask : pop
  task automatic wr_addr(input logic [5:0] a);
    wr <= 1'b1;
    waddr <= a;
    step(1);
    wr <= 1'b0;
    step(3);
  endtask : wr_addr
  task automatic t_addr;
    chk({2'b00, addr}, {2'b00, ADDR_DEF});
    wr_addr(ADDR_MS_MIN);
    chk({2'b00, addr}, {2'b00, ADDR_DEF});
    chk(8'(n_save), 8'h00);
    wr_addr(ADDR_SA_MAX);
    chk({2'b00, addr}, {2'b00, ADDR_SA_MAX});
    chk(8'(n_save), 8'h01);
    master <= 1'b1;
    wr_addr(ADDR_MS_MIN);
    chk({2'b00, addr}, {2'b00, ADDR_MS_MIN});
    master <= 1'b0;
    wr_addr(ADDR_DEF);
    $display("t_addr done");
  endtask : t_addr
  task automatic t_listen;
    ctl_send(1'b1, MLA);
    chk({5'h00, lsn, talk, rem}, 8'h05);
    for (int i = 0; i < FIFO_DEPTH; i++) ctl_send(1'b0, 8'h30 + 8'(i));
    ctl_start(1'b0, 8'h34);
    step(100);
    // a full receive buffer must hold the handshake off
    chk({6'h00, gpib_if_inst.dav, gpib_if_inst.nrfd}, 8'h01);
    for (int i = 0; i <= FIFO_DEPTH; i++) pop(8'h30 + 8'(i));
    $display("t_listen done");
  endtask : t_listen
  task automatic t_cmds;
    ctl_send(1'b1, {1'b0, CMD_GET});
    chk(8'(n_trig), 8'h01);
    ctl_send(1'b1, {1'b0, CMD_DCL});
    chk(8'(n_clr), 8'h01);
    ctl_send(1'b1, {1'b0, CMD_LLO});
    chk({7'h00, lock}, 8'h01);
    ctl_send(1'b1, {1'b0, CMD_UNL});
    chk({7'h00, lsn}, 8'h00);
    // own address in the secondary group must not address the device
    ctl_send(1'b1, {3'b011, ADDR_DEF[4:0]});
    chk({6'h00, talk, lsn}, 8'h00);
    ctl_send(1'b1, {1'b0, CMD_GET});
    chk(8'(n_trig), 8'h01);
    ctl_send(1'b1, {1'b0, CMD_SDC});
    chk(8'(n_clr), 8'h01);
    ctl_send(1'b1, MLA);
    ifc_i <= 1'b1;
    step(1);
    ifc_i <= 1'b0;
    step(2600);
    chk({6'h00, lsn, ifc_bsy}, 8'h00);
    $display("t_cmds done");
  endtask : t_cmds
  task automatic t_talk;
    rx_en <= 1'b1;
    ctl_send(1'b1, MLA);
    atn_i <= 1'b0;
    d_tv <= 1'b1;
    d_td <= 8'h5a;
    step(80);
    chk({7'h00, gpib_if_inst.dav}, 8'h00);
    d_tv <= 1'b0;
    tsrc <= TRIG_TALK;
    ctl_send(1'b1, MTA);
    chk({6'h00, talk, lsn}, 8'h02);
    chk(8'(n_trig), 8'h02);
    atn_i <= 1'b0;
    step(3);
    d_tv <= 1'b1;
    d_td <= 8'ha5;
    d_te <= 1'b1;
    for (int i = 0; i < 400 && d_rdy !== 1'b1; i++) step(1);
    lim(d_rdy === 1'b1);
    d_tv <= 1'b0;
    ctl_rx(8'ha5);
    chk({7'h00, c_re}, 8'h01);
    ctl_send(1'b1, MLA);
    chk({6'h00, talk, lsn}, 8'h01);
    $display("t_talk done");
  endtask : t_talk
  task automatic t_poll;
    stat <= 6'h2a;
    srq_rq <= 1'b1;
    step(1);
    srq_rq <= 1'b0;
    step(4);
    chk({7'h00, c_srq}, 8'h01);
    ctl_send(1'b1, {1'b0, CMD_SPE});
    ctl_send(1'b1, MTA);
    atn_i <= 1'b0;
    ctl_rx({2'b01, 6'h2a});
    chk({7'h00, c_re}, 8'h00);
    ctl_send(1'b1, {1'b0, CMD_SPD});
    chk({7'h00, c_srq}, 8'h00);
    $display("t_poll done");
  endtask : t_poll
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    step(8);
    rst_i <= 1'b0;
    step(2);
    t_addr;
    t_listen;
    t_cmds;
    t_talk;
    t_poll;
    summarize;
  end
  // the tests need about a sixth of this span
  initial begin
    #1000000;
    err_count++;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
